// [shared/fpi_pkg.sv]
package fpi_pkg;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam logic [19:0] CFG_ADDR    = 20'h2_4a00;
  localparam logic [19:0] STAT_ADDR   = 20'h2_4a04;
  localparam logic [19:0] IEVT_ADDR   = 20'h2_4a08;
  localparam logic [19:0] IMSK_ADDR   = 20'h2_4a0c;
  localparam logic [19:0] ECTL_ADDR   = 20'h2_4a10;

  // ****************************************************************
  // Configuration field positions (bit 0 is the least significant).
  // ****************************************************************
  localparam int GAP_LSB  = 16;
  localparam int GAP_MSB  = 23;
  localparam int RRST_BIT = 15;
  localparam int TRST_BIT = 14;
  localparam int RXE_BIT  = 13;
  localparam int TXE_BIT  = 12;
  localparam int LPB_BIT  = 8;
  localparam int RFCE_BIT = 7;
  localparam int TFCE_BIT = 6;
  localparam int FFC_BIT  = 5;
  localparam int CAPP_BIT = 4;
  localparam int CCHK_BIT = 3;
  localparam int SIGNALING_MODE_LSB = 0;
  localparam int SIGNALING_MODE_MSB = 1;
  localparam logic [31:0] CFG_MASK  = 32'h00ff_f1fb;
  localparam logic [31:0] CFG_RESET = 32'h0000_00c0;

  localparam logic [1:0] SIGNALING_MODE_GMII = 2'h0;
  localparam logic [1:0] SIGNALING_MODE_ENC  = 2'h1;

  // ****************************************************************
  // Event bits.
  // ****************************************************************
  localparam int EV_TXDONE = 0;
  localparam int EV_RXDONE = 1;
  localparam int EV_CRCERR = 2;
  localparam int EV_UNDER  = 3;
  localparam int NUM_EV    = 4;

  localparam logic [31:0] CRC_INIT    = 32'hffff_ffff;
  localparam logic [31:0] CRC_POLY    = 32'hedb8_8320;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb_20e3;

  typedef enum logic [2:0] {
    TX_IDLE, TX_DATA, TX_CRC, TX_GAP
  } fpi_tx_state_t;

endpackage

// [rtl/fpi_top.sv]
// Added by the designer: register access over APB.
module fpi_top (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        dma_tx_valid,
  input  wire logic [7:0]  dma_tx_data,
  input  wire logic        dma_tx_last,
  input  wire logic        dma_tx_crc_req,
  output logic             dma_tx_ready,
  input  wire logic        dma_rx_pause_need,
  output logic             dma_rx_valid,
  output logic [7:0]       dma_rx_data,
  output logic             dma_rx_last,
  output logic             dma_rx_crc_error,
  output logic [7:0]       fifo_txd,
  output logic             fifo_tx_en,
  output logic             fifo_tx_er,
  input  wire logic [7:0]  fifo_rxd,
  input  wire logic        fifo_rx_dv,
  input  wire logic        fifo_rx_er,
  output logic             receive_flow_ctrl_signal
);

  // ****************************************************************
  // Reset synchroniser.
  // ****************************************************************
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  d);
    logic [31:0] r;
    r = c ^ {24'h00_0000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ fpi_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ****************************************************************
  // APB slave and registers.
  // ****************************************************************
  logic [31:0] cfg_q;
  logic        fifo_mode_select_q;
  logic [fpi_pkg::NUM_EV-1:0] ev_q;
  logic [fpi_pkg::NUM_EV-1:0] msk_q;
  logic [fpi_pkg::NUM_EV-1:0] ev_set;

  wire acc      = psel && penable && ce;
  wire wr       = acc && pwrite && pready;
  wire [19:0] a = paddr[19:0];
  wire hit_cfg  = (a == fpi_pkg::CFG_ADDR);
  wire hit_stat = (a == fpi_pkg::STAT_ADDR);
  wire hit_evt  = (a == fpi_pkg::IEVT_ADDR);
  wire hit_msk  = (a == fpi_pkg::IMSK_ADDR);
  wire hit_ectl = (a == fpi_pkg::ECTL_ADDR);
  wire hit_any  = (paddr[31:20] == 12'h000) &&
                  (hit_cfg || hit_stat || hit_evt || hit_msk || hit_ectl);

  wire [7:0] gap_cfg  = cfg_q[fpi_pkg::GAP_MSB:fpi_pkg::GAP_LSB];
  wire       rrst     = cfg_q[fpi_pkg::RRST_BIT];
  wire       trst     = cfg_q[fpi_pkg::TRST_BIT];
  wire       fifo_receive_enable      = cfg_q[fpi_pkg::RXE_BIT];
  wire       fifo_transmit_enable      = cfg_q[fpi_pkg::TXE_BIT];
  wire       internal_loopback      = cfg_q[fpi_pkg::LPB_BIT];
  wire       rfce     = cfg_q[fpi_pkg::RFCE_BIT];
  wire       tfce     = cfg_q[fpi_pkg::TFCE_BIT];
  wire       ffc      = cfg_q[fpi_pkg::FFC_BIT];
  wire       capp     = cfg_q[fpi_pkg::CAPP_BIT];
  wire       cchk     = cfg_q[fpi_pkg::CCHK_BIT];
  wire [1:0] signaling_mode     = cfg_q[fpi_pkg::SIGNALING_MODE_MSB:fpi_pkg::SIGNALING_MODE_LSB];
  wire       enc_mode = (signaling_mode == fpi_pkg::SIGNALING_MODE_ENC);
  wire       tx_on    = fifo_mode_select_q && fifo_transmit_enable && !trst;
  wire       rx_on    = fifo_mode_select_q && fifo_receive_enable && !rrst;

  fpi_pkg::fpi_tx_state_t tx_st_q;
  wire [31:0] stat_word = {28'h000_0000, tx_st_q != fpi_pkg::TX_IDLE,
                           receive_flow_ctrl_signal, tx_on, rx_on};

  wire [31:0] rd_word =
    hit_cfg  ? cfg_q :
    hit_stat ? stat_word :
    hit_evt  ? {28'h000_0000, ev_q} :
    hit_msk  ? {28'h000_0000, msk_q} :
    hit_ectl ? {31'h0000_0000, fifo_mode_select_q} : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= psel && penable && !pready;
      prdata  <= rd_word;
      pslverr <= psel && penable && !pready && !hit_any;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_q  <= fpi_pkg::CFG_RESET;
      fifo_mode_select_q <= 1'b0;
      msk_q  <= '0;
    end else if (wr && hit_any) begin
      if (hit_cfg) cfg_q <= pwdata & fpi_pkg::CFG_MASK;
      if (hit_ectl) fifo_mode_select_q <= pwdata[0];
      if (hit_msk) msk_q <= pwdata[fpi_pkg::NUM_EV-1:0];
    end
  end

  // Set wins over a write-one clear in the same cycle.
  wire [fpi_pkg::NUM_EV-1:0] ev_clr =
    (wr && hit_evt && hit_any) ? pwdata[fpi_pkg::NUM_EV-1:0] : '0;
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ev_q <= '0;
      irq  <= 1'b0;
    end else if (ce) begin
      ev_q <= (ev_q & ~ev_clr) | ev_set;
      irq  <= |(((ev_q & ~ev_clr) | ev_set) & msk_q);
    end
  end

  // ****************************************************************
  // Transmitter.
  // ****************************************************************
  logic [31:0] tcrc_q;
  logic [1:0]  tcnt_q;
  logic [7:0]  gcnt_q;
  logic        tadd_q;
  logic [7:0]  ltxd_q;
  logic        ltxv_q;
  logic        tx_done;
  logic        tx_under;

  wire in_data   = (tx_st_q == fpi_pkg::TX_DATA);
  wire take      = tx_on && in_data && dma_tx_valid;
  wire add_crc   = capp || dma_tx_crc_req;
  wire [31:0] tcrc_fin = ~tcrc_q;
  wire [7:0]  crc_out  = tcrc_fin[8*tcnt_q +: 8];
  wire [7:0]  tx_byte  = (tx_st_q == fpi_pkg::TX_CRC) ? crc_out
                                                       : dma_tx_data;
  wire tx_drive = take || (tx_on && tx_st_q == fpi_pkg::TX_CRC);
  // A stall with flow control enabled in the encoded signaling mode is a pause; otherwise, an underrun.
  wire stall_pause = enc_mode && tfce;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_st_q <= fpi_pkg::TX_IDLE;
      tcrc_q  <= fpi_pkg::CRC_INIT;
      tcnt_q  <= 2'h0;
      gcnt_q  <= 8'h00;
      tadd_q  <= 1'b0;
    end else if (ce) begin
      if (!tx_on) begin
        tx_st_q <= fpi_pkg::TX_IDLE;
        tcrc_q  <= fpi_pkg::CRC_INIT;
      end else begin
        case (tx_st_q)
          fpi_pkg::TX_IDLE: begin
            if (dma_tx_valid) tx_st_q <= fpi_pkg::TX_DATA;
            tcrc_q <= fpi_pkg::CRC_INIT;
          end
          fpi_pkg::TX_DATA: begin
            if (take) begin
              tcrc_q <= crc_byte(tcrc_q, dma_tx_data);
              if (dma_tx_last) begin
                tadd_q  <= add_crc;
                tcnt_q  <= 2'h0;
                gcnt_q  <= gap_cfg;
                tx_st_q <= add_crc ? fpi_pkg::TX_CRC : fpi_pkg::TX_GAP;
              end
            end else if (!stall_pause) begin
              gcnt_q  <= gap_cfg;
              tx_st_q <= fpi_pkg::TX_GAP;
            end
          end
          fpi_pkg::TX_CRC: begin
            tcnt_q <= tcnt_q + 2'h1;
            if (tcnt_q == 2'h3) tx_st_q <= fpi_pkg::TX_GAP;
          end
          fpi_pkg::TX_GAP: begin
            if (gcnt_q <= 8'h01) tx_st_q <= fpi_pkg::TX_IDLE;
            gcnt_q <= gcnt_q - 8'h01;
          end
          default: tx_st_q <= fpi_pkg::TX_IDLE;
        endcase
      end
    end
  end

  assign tx_done  = tx_on && ((take && dma_tx_last && !add_crc) ||
                    (tx_st_q == fpi_pkg::TX_CRC && tcnt_q == 2'h3));
  assign tx_under = tx_on && in_data && !dma_tx_valid && !stall_pause;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fifo_txd     <= 8'h00;
      fifo_tx_en   <= 1'b0;
      fifo_tx_er   <= 1'b0;
      ltxd_q       <= 8'h00;
      ltxv_q       <= 1'b0;
      dma_tx_ready <= 1'b0;
    end else if (ce) begin
      dma_tx_ready <= tx_on && (tx_st_q == fpi_pkg::TX_IDLE ||
                      (in_data && !(take && dma_tx_last)));
      fifo_txd     <= (tx_drive && !internal_loopback) ? tx_byte : 8'h00;
      fifo_tx_en   <= tx_drive && !internal_loopback;
      fifo_tx_er   <= tx_under && !internal_loopback;
      ltxd_q       <= tx_byte;
      ltxv_q       <= tx_drive && internal_loopback;
    end
  end

  // ****************************************************************
  // Receiver.
  // ****************************************************************
  logic [31:0] rcrc_q;
  logic [2:0]  rcnt_q;
  logic        rdv_q;
  wire  [7:0]  rx_byte = internal_loopback ? ltxd_q : fifo_rxd;
  wire         rx_dv   = rx_on && (internal_loopback ? ltxv_q : fifo_rx_dv);
  wire         rx_end  = rx_on && rdv_q && !rx_dv;
  wire [31:0]  rcrc_n  = crc_byte(rcrc_q, rx_byte);
  // Short frames cannot hold a CRC and count as errors.
  wire         crc_bad = cchk && ((rcrc_q != fpi_pkg::CRC_RESIDUE) ||
                         (rcnt_q < 3'h4));

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rcrc_q <= fpi_pkg::CRC_INIT;
      rcnt_q <= 3'h0;
      rdv_q  <= 1'b0;
    end else if (ce) begin
      rdv_q <= rx_dv;
      if (!rx_on || !rx_dv) begin
        rcrc_q <= fpi_pkg::CRC_INIT;
        rcnt_q <= 3'h0;
      end else begin
        rcrc_q <= rcrc_n;
        if (rcnt_q != 3'h7) rcnt_q <= rcnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dma_rx_valid             <= 1'b0;
      dma_rx_data              <= 8'h00;
      dma_rx_last              <= 1'b0;
      dma_rx_crc_error         <= 1'b0;
      receive_flow_ctrl_signal <= 1'b0;
    end else if (ce) begin
      dma_rx_valid     <= rx_dv || rx_end;
      dma_rx_data      <= rx_dv ? rx_byte : 8'h00;
      dma_rx_last      <= rx_end;
      dma_rx_crc_error <= rx_end && crc_bad;
      receive_flow_ctrl_signal <= fifo_mode_select_q && !rrst &&
        ((ffc && enc_mode) || (rfce && dma_rx_pause_need));
    end
  end

  assign ev_set = {tx_under, rx_end && crc_bad, rx_end, tx_done};

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  AST_GAP: assert property (@(posedge clk) disable iff (!rst_n_q)
    ce && tx_on && tx_st_q == fpi_pkg::TX_GAP && gcnt_q > 8'h01 |=>
    tx_st_q == fpi_pkg::TX_GAP) else $error("gap ended early");
  AST_TXOFF: assert property (@(posedge clk) disable iff (!rst_n_q)
    ce && !fifo_transmit_enable |=> !fifo_tx_en) else $error("tx while disabled");
  AST_TRST: assert property (@(posedge clk) disable iff (!rst_n_q)
    ce && trst |=> tx_st_q == fpi_pkg::TX_IDLE) else $error("tx not held");
  AST_RXOFF: assert property (@(posedge clk) disable iff (!rst_n_q)
    ce && !fifo_receive_enable |=> !dma_rx_valid)
    else $error("rx while disabled");
  AST_LPB: assert property (@(posedge clk) disable iff (!rst_n_q)
    ce && internal_loopback |=> !fifo_tx_en) else $error("pins driven in loopback");
  AST_FFC: assert property (@(posedge clk) disable iff (!rst_n_q)
    ce && fifo_mode_select_q && !rrst && ffc && enc_mode |=> receive_flow_ctrl_signal)
    else $error("forced flow control missing");
  AST_RFC: assert property (@(posedge clk) disable iff (!rst_n_q)
    ce && !rfce && !(ffc && enc_mode) |=> !receive_flow_ctrl_signal)
    else $error("flow control while disabled");
  AST_CRCN: assert property (@(posedge clk) disable iff (!rst_n_q)
    ce && take && dma_tx_last && capp |=> tx_st_q == fpi_pkg::TX_CRC)
    else $error("crc not appended");
  AST_SHORT: assert property (@(posedge clk) disable iff (!rst_n_q)
    ce && rx_end && cchk && rcnt_q < 3'h4 |=> dma_rx_crc_error)
    else $error("short frame not flagged");
  AST_FIFO_MODE_SELECT: assert property (@(posedge clk) disable iff (!rst_n_q)
    ce && !fifo_mode_select_q |=> !fifo_tx_en && !rdv_q) else $error("fifo mode off");
  AST_PAUSE: assert property (@(posedge clk) disable iff (!rst_n_q)
    ce && tx_on && in_data && !dma_tx_valid && stall_pause |=>
    tx_st_q == fpi_pkg::TX_DATA && !fifo_tx_er) else $error("no pause");
  AST_UNDER: assert property (@(posedge clk) disable iff (!rst_n_q)
    ce && tx_on && in_data && !dma_tx_valid && !stall_pause && !internal_loopback |=>
    fifo_tx_er) else $error("underrun not flagged");

  COV_TXCRC: cover property (@(posedge clk) tx_st_q == fpi_pkg::TX_CRC);
  COV_RXERR: cover property (@(posedge clk) dma_rx_crc_error);
  COV_LPB: cover property (@(posedge clk) ltxv_q);
  COV_IRQ: cover property (@(posedge clk) irq);

endmodule

// [tb/fpi_fifo_peer.sv]
module fpi_fifo_peer (
  input  wire logic       clk,
  output logic [7:0]      rxd,
  output logic            rx_dv,
  output logic            rx_er
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] frame_q[$];

  initial begin
    rxd   = 8'h5a;
    rx_dv = 1'b0;
    rx_er = 1'b0;
  end

  // Between frames the data lines toggle so a stale byte is never seen.
  always @(posedge clk) begin
    if (frame_q.size() > 0) begin
      rx_dv <= 1'b1;
      rxd   <= frame_q.pop_front();
    end else begin
      rx_dv <= 1'b0;
      rxd   <= ~rxd;
    end
  end
endmodule

// [tb/tb_fifo_packet_interface.sv]
module tb_fifo_packet_interface;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, arst_n, ce, psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0] paddr, pwdata, prdata, w;
  logic        dma_tx_valid, dma_tx_last, dma_tx_crc_req, dma_tx_ready;
  logic [7:0]  dma_tx_data, dma_rx_data, fifo_txd, fifo_rxd;
  logic        dma_rx_pause_need, dma_rx_valid, dma_rx_last;
  logic        dma_rx_crc_error, fifo_tx_en, fifo_tx_er, fifo_rx_dv;
  logic        fifo_rx_er, receive_flow_ctrl_signal;
  logic [32:0] exp_rd[$];
  logic [7:0]  exp_tx[$], exp_rx[$];
  logic        exp_end[$], exp_er[$];
  int          fail_count, n_tests, idle_cnt, gap_v;
  integer      seed;

  localparam logic [31:0] M_RRST = 32'h1 << fpi_pkg::RRST_BIT;
  localparam logic [31:0] M_TRST = 32'h1 << fpi_pkg::TRST_BIT;
  localparam logic [31:0] M_RXE  = 32'h1 << fpi_pkg::RXE_BIT;
  localparam logic [31:0] M_TXE  = 32'h1 << fpi_pkg::TXE_BIT;
  localparam logic [31:0] M_LPB  = 32'h1 << fpi_pkg::LPB_BIT;
  localparam logic [31:0] M_RFCE = 32'h1 << fpi_pkg::RFCE_BIT;
  localparam logic [31:0] M_TFCE = 32'h1 << fpi_pkg::TFCE_BIT;
  localparam logic [31:0] M_FFC  = 32'h1 << fpi_pkg::FFC_BIT;
  localparam logic [31:0] M_CAPP = 32'h1 << fpi_pkg::CAPP_BIT;
  localparam logic [31:0] M_CCHK = 32'h1 << fpi_pkg::CCHK_BIT;
  localparam logic [31:0] G3     = 32'h3 << fpi_pkg::GAP_LSB;
  localparam logic [31:0] G7     = 32'h7 << fpi_pkg::GAP_LSB;
  localparam logic [19:0] CFG    = fpi_pkg::CFG_ADDR;
  // Entries are {mode[1:0], force, enable, need, expected flow control}.
  localparam logic [5:0] FC[5] = '{6'h19, 6'h08, 6'h07, 6'h02, 6'h14};

  fpi_top dut_u (
    .clk, .arst_n, .ce, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .irq, .dma_tx_valid, .dma_tx_data,
    .dma_tx_last, .dma_tx_crc_req, .dma_tx_ready, .dma_rx_pause_need,
    .dma_rx_valid, .dma_rx_data, .dma_rx_last, .dma_rx_crc_error,
    .fifo_txd, .fifo_tx_en, .fifo_tx_er, .fifo_rxd, .fifo_rx_dv,
    .fifo_rx_er, .receive_flow_ctrl_signal
  );

  fpi_fifo_peer peer_u (
    .clk(clk), .rxd(fifo_rxd), .rx_dv(fifo_rx_dv), .rx_er(fifo_rx_er)
  );

  // ****************************************************************
  // Clock, time-zero values and shared tasks.
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    {arst_n, psel, penable, pwrite, dma_tx_valid, dma_tx_last} = '0;
    {dma_tx_crc_req, dma_rx_pause_need, paddr, pwdata, dma_tx_data} = '0;
    ce       = 1'b1;
    seed     = 32'h5080_4179;
    idle_cnt = 1000;
  end

  function automatic logic [31:0] crc8(input logic [31:0] c,
                                       input logic [7:0]  b);
    logic [31:0] r;
    r = c ^ {24'h00_0000, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ 32'hedb8_8320) : (r >> 1);
    return r;
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] exp,
                       input string what);
    n_tests++;
    if (seen !== exp || $isunknown(seen)) begin
      fail_count++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic endtest(input string name);
    check(exp_tx.size() + exp_rx.size() + exp_end.size() + exp_er.size(),
          0, name);
    $display("test %s done", name);
  endtask

  task automatic apb(input logic wr, input logic [19:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {12'h000, a};
    pwdata <= d;
    if (!wr)
      exp_rd.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rx_frame(input int n, input logic crcb,
                          input logic [7:0] bad, input logic seen,
                          input logic err);
    logic [31:0] c;
    logic [7:0]  b;
    c = 32'hffff_ffff;
    for (int i = 0; i < n + (crcb ? 4 : 0); i++) begin
      b = (i < n) ? 8'($random(seed)) : 8'(~c >> (8 * (i - n)));
      if (i < n)
        c = crc8(c, b);
      b = b ^ ((i == n) ? bad : 8'h00);
      peer_u.frame_q.push_back(b);
      if (seen)
        exp_rx.push_back(b);
    end
    if (seen)
      exp_end.push_back(err);
    repeat (n + 12) @(posedge clk);
  endtask

  task automatic dma_send(input int nf, input int n, input logic req,
                          input logic app, input logic internal_loopback);
    logic [31:0] c;
    logic [7:0]  b;
    for (int f = 0; f < nf; f++) begin
      c = 32'hffff_ffff;
      for (int i = 0; i < n; i++) begin
        b = 8'($random(seed));
        c = crc8(c, b);
        if (internal_loopback)
          exp_rx.push_back(b);
        else
          exp_tx.push_back(b);
        dma_tx_valid   <= 1'b1;
        dma_tx_data    <= b;
        dma_tx_last    <= (i == n - 1);
        dma_tx_crc_req <= req;
        // The edge that starts a frame takes no byte.
        if (i == 0)
          @(posedge clk);
        do begin
          @(posedge clk);
        end while (dma_tx_ready !== 1'b1);
      end
      for (int j = 0; j < 4 && app; j++)
        exp_tx.push_back(8'(~c >> (8 * j)));
      if (internal_loopback)
        exp_end.push_back(1'b0);
    end
    dma_tx_valid <= 1'b0;
    dma_tx_last  <= 1'b0;
    @(posedge clk);
  endtask

  // ****************************************************************
  // Output watcher: each read, rx, underrun and tx byte result takes the oldest note off its queue.
  // ****************************************************************
  always @(posedge clk) begin
    if (pready === 1'b1 && psel && !pwrite)
      check({pslverr, prdata}, exp_rd.size() ? exp_rd.pop_front() : 'x,
            "read");
    if (dma_rx_valid === 1'b1 && dma_rx_last === 1'b1)
      check(dma_rx_crc_error, exp_end.size() ? exp_end.pop_front() : 1'bx,
            "rx end");
    else if (dma_rx_valid === 1'b1)
      check(dma_rx_data, exp_rx.size() ? exp_rx.pop_front() : 8'hxx,
            "rx byte");
    if (fifo_tx_er === 1'b1)
      check(fifo_tx_er, exp_er.size() ? exp_er.pop_front() : 1'bx,
            "underrun");
    if (fifo_tx_en === 1'b1) begin
      check(fifo_txd, exp_tx.size() ? exp_tx.pop_front() : 8'hxx,
            "tx byte");
      if (idle_cnt > 0 && idle_cnt < gap_v)
        check(33'(idle_cnt), 33'(gap_v), "frame gap");
      idle_cnt <= 0;
    end else if (idle_cnt < 1000)
      idle_cnt <= idle_cnt + 1;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, CFG, 0, {1'b0, fpi_pkg::CFG_RESET});
    apb(1'b0, 20'h2_4a40, 0, 33'h1_0000_0000);
    w = $random(seed) & 32'hffff_fffd;
    apb(1'b1, CFG, w, 0);
    apb(1'b0, CFG, 0, {1'b0, w & fpi_pkg::CFG_MASK});
    endtest("registers");
    apb(1'b1, CFG, M_RXE | M_CCHK | G3, 0);
    rx_frame(6, 1'b1, 8'h00, 1'b0, 1'b0);
    apb(1'b1, fpi_pkg::ECTL_ADDR, 32'h1, 0);
    apb(1'b1, fpi_pkg::IEVT_ADDR, 32'hffff_ffff, 0);
    apb(1'b1, fpi_pkg::IMSK_ADDR, 32'h1 << fpi_pkg::EV_RXDONE, 0);
    check(irq, 1'b0, "irq idle");
    rx_frame(8, 1'b1, 8'h00, 1'b1, 1'b0);
    check(irq, 1'b1, "irq set");
    apb(1'b1, fpi_pkg::IEVT_ADDR, 32'h1 << fpi_pkg::EV_RXDONE, 0);
    check(irq, 1'b0, "irq clear");
    rx_frame(8, 1'b1, 8'h40, 1'b1, 1'b1);
    rx_frame(2, 1'b0, 8'h00, 1'b1, 1'b1);
    apb(1'b1, CFG, M_RXE | G3, 0);
    rx_frame(5, 1'b1, 8'h40, 1'b1, 1'b0);
    apb(1'b1, CFG, G3, 0);
    rx_frame(5, 1'b1, 8'h00, 1'b0, 1'b0);
    apb(1'b1, CFG, M_RXE | M_RRST | G3, 0);
    rx_frame(5, 1'b1, 8'h00, 1'b0, 1'b0);
    endtest("receive");
    gap_v = 7;
    apb(1'b1, CFG, M_TXE | M_CAPP | G7, 0);
    dma_send(2, 5, 1'b0, 1'b1, 1'b0);
    repeat (30) @(posedge clk);
    gap_v = 3;
    apb(1'b1, CFG, M_TXE | G3, 0);
    dma_send(1, 4, 1'b1, 1'b1, 1'b0);
    dma_send(1, 4, 1'b0, 1'b0, 1'b0);
    repeat (30) @(posedge clk);
    endtest("transmit");
    apb(1'b1, CFG, M_TXE | M_RXE | M_LPB | G3, 0);
    dma_send(1, 6, 1'b0, 1'b0, 1'b1);
    repeat (30) @(posedge clk);
    endtest("loopback");
    for (int i = 0; i < 2; i++) begin
      w = i ? (M_TFCE | 32'(fpi_pkg::SIGNALING_MODE_ENC)) : 32'h0000_0000;
      apb(1'b1, CFG, w | M_TXE | G3, 0);
      dma_tx_valid <= 1'b1;
      dma_tx_data  <= 8'($random(seed));
      repeat (2) @(posedge clk);
      exp_tx.push_back(dma_tx_data);
      dma_tx_valid <= 1'b0;
      if (i == 0)
        exp_er.push_back(1'b1);
      else begin
        repeat (4) @(posedge clk);
        exp_tx.push_back(dma_tx_data);
        dma_tx_valid <= 1'b1;
        dma_tx_last  <= 1'b1;
        @(posedge clk);
        dma_tx_valid <= 1'b0;
        dma_tx_last  <= 1'b0;
      end
      repeat (20) @(posedge clk);
    end
    endtest("stall");
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, CFG, i ? (M_TXE | M_TRST | G3) : G3, 0);
      dma_tx_valid <= 1'b1;
      repeat (20) @(posedge clk);
      dma_tx_valid <= 1'b0;
      @(posedge clk);
    end
    endtest("transmit off");
    for (int i = 0; i < 5; i++) begin
      w = (FC[i][3] ? M_FFC : 0) | (FC[i][2] ? M_RFCE : 0);
      apb(1'b1, CFG, w | M_RXE | G3 | 32'(FC[i][5:4]), 0);
      dma_rx_pause_need <= FC[i][1];
      repeat (3) @(posedge clk);
      check(receive_flow_ctrl_signal, FC[i][0], "flow control");
    end
    endtest("flow control");
    close_out();
  end
endmodule
